//--- scdg_pkg.sv
// Shared constants, types and encodings of the secure config loader
package scdg_pkg;
	// Datapath widths
	localparam int WORD_W = 32;
	localparam int LOAD_W = 16;
	localparam int MEM_AW = 12;
	localparam int MEM_DEPTH = 4096;
	localparam int FIFO_DEPTH = 8;
	// Cipher block geometry
	localparam int CBLK_SHIFT = 2;
	localparam int GROUP_WORDS = 8;
	// Least key-rolling block sizes, in cipher blocks
	localparam logic [15:0] CC_MIN_CBLK = 16'h0004;
	localparam logic [15:0] AUTH_MIN_GEN1 = 16'h00F6;
	localparam logic [15:0] AUTH_MIN_GEN2 = 16'h00BA;
	// Reset values
	localparam logic [31:0] KEY_RST = 32'h0000_0000;
	localparam logic [2:0] TMR_RST = 3'h0;

	// Load port width per transfer
	typedef enum logic [1:0] {
		SCDG_X1 = 2'h0,
		SCDG_X4 = 2'h1,
		SCDG_X8 = 2'h2,
		SCDG_X16 = 2'h3
	} scdg_width_t;

	// Loader states, Gray along the usual path
	typedef enum logic [2:0] {
		SCDG_IDLE = 3'h0,
		SCDG_LOAD = 3'h1,
		SCDG_AUTH = 3'h3,
		SCDG_RDWR = 3'h2,
		SCDG_RDWW = 3'h6,
		SCDG_DONE = 3'h7,
		SCDG_ERR = 3'h5
	} scdg_state_t;

	// Error causes
	typedef enum logic [2:0] {
		SCDG_E_NONE = 3'h0,
		SCDG_E_MODE = 3'h1,
		SCDG_E_FEAT = 3'h2,
		SCDG_E_FUSE = 3'h3,
		SCDG_E_BLK = 3'h4,
		SCDG_E_OVF = 3'h5,
		SCDG_E_CHK = 3'h6,
		SCDG_E_AUTH = 3'h7
	} scdg_err_t;

	// Configuration header options
	typedef struct packed {
		logic counting;
		logic auth;
		logic key_roll;
		logic encrypted;
		logic compressed;
		logic partial;
		logic staged;
		logic gen2;
	} scdg_cfg_t;

	// Fuse states
	typedef struct packed {
		logic hash_prog;
		logic scan_disable_fuse;
	} scdg_fuse_t;
endpackage : scdg_pkg

//--- scdg_fifo.sv
// Word FIFO between load packer and decrypt engine
`timescale 1ns/100ps
module scdg_fifo #(
	parameter int W = 32,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Fill side
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [W-1:0] i_in_data,
	// Drain side
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [W-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_q [DEPTH];
	logic [AW:0] wp_q;
	logic [AW:0] rp_q;
	logic push;
	logic pop;

	// Full and empty from pointer wrap bits
	assign o_in_ready = !((wp_q[AW] != rp_q[AW]) &&
		(wp_q[AW-1:0] == rp_q[AW-1:0]));
	assign o_out_valid = (wp_q != rp_q);
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;
	assign o_out_data = mem_q[rp_q[AW-1:0]];

	// Storage
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_q[wp_q[AW-1:0]] <= i_in_data;
		end
	end

	// Pointers
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			if (push) begin
				wp_q <= wp_q + {{AW{1'b0}}, 1'b1};
			end
			if (pop) begin
				rp_q <= rp_q + {{AW{1'b0}}, 1'b1};
			end
		end
	end
endmodule : scdg_fifo

//--- scdg_loader.sv
// Secure configuration loader with DPA guards and readback lock
//
// Behaviour
// - Auth mode stores whole bitstream first; memory size bounds it
// - Read-decrypt-write pass uses a 32-bit path on the config clock
// - Load port takes 1, 4, 8 or 16 bits per transfer
// - Key-rolling block size is programmable; each block has its own key
// - Only key 0 is on chip; later keys come from prior payload
// - At most one of counting and auth countermeasures enabled
// - Counting mode needs at least four cipher blocks per key
// - Auth mode needs the key hash fuses programmed
// - Auth mode rejects compressed, partial and staged bitstreams
// - Protected load blocks all external readback, triple redundant
// - Internal access port still reads back after protected load
// - Hardened block overrides the soft readback-disable bit
// - Scan forced off when decryption or authentication enabled
// - Scan-disable fuse turns scan off permanently
// - Counting mode checks a tag every eight words, halts on fail
// - In auth mode each frame is read, decrypted and written back in place
// - Auth mode skips the periodic tag checks
`timescale 1ns/100ps
module scdg_loader (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Session control
	input wire logic i_start,
	input wire scdg_pkg::scdg_cfg_t i_cfg,
	input wire scdg_pkg::scdg_fuse_t i_fuse,
	input wire logic [15:0] i_block_cblocks,
	input wire logic [31:0] i_key0,
	input wire logic i_auth_ok,
	input wire logic i_auth_fail,
	// Load port
	input wire scdg_pkg::scdg_width_t i_load_width,
	input wire logic i_load_valid,
	input wire logic [15:0] i_load_data,
	input wire logic i_load_end,
	output logic o_load_ready,
	// Readback ports
	input wire logic i_soft_rb_dis,
	input wire logic i_ext_rb_req,
	input wire logic [11:0] i_ext_rb_addr,
	input wire logic i_icap_rd_en,
	input wire logic [11:0] i_icap_addr,
	output logic o_ext_rb_valid,
	output logic o_icap_rd_valid,
	output logic [31:0] o_rd_data,
	// Status and test
	input wire logic i_scan_req,
	output logic o_scan_enable,
	output logic o_rb_locked,
	output logic o_done,
	output scdg_pkg::scdg_err_t o_err
);
	scdg_pkg::scdg_state_t state_q;
	scdg_pkg::scdg_cfg_t cfg_q;
	scdg_pkg::scdg_err_t err_q;
	logic [31:0] mem [scdg_pkg::MEM_DEPTH];
	logic [31:0] acc_q;
	logic [5:0] bits_q;
	logic pend_q;
	logic [31:0] word_q;
	logic end_q;
	logic f_valid;
	logic f_ready;
	logic [31:0] f_data;
	logic in_ready;
	logic take;
	logic [31:0] key_q;
	logic [17:0] blk_q;
	logic [17:0] blk_words;
	logic [3:0] grp_q;
	logic [31:0] sum_q;
	logic chk_q;
	logic chk_ok_q;
	logic [12:0] wr_cnt_q;
	logic [11:0] rdw_q;
	logic [31:0] rd_q;
	logic [2:0] prot_q;
	logic prot;
	logic scan_off_q;
	logic [5:0] step;
	logic [31:0] shifted;
	logic [31:0] plain;
	logic is_tag;
	logic mem_we;
	logic [11:0] mem_wa;
	logic [31:0] mem_wd;
	logic [11:0] rd_a;
	logic [15:0] min_cblk;
	logic start_err;
	scdg_pkg::scdg_err_t start_code;
	logic fifo_rst_n;

	// Packer shift per transfer width
	always_comb begin
		unique case (i_load_width)
			scdg_pkg::SCDG_X1: begin
				step = 6'h01;
				shifted = {acc_q[30:0], i_load_data[0]};
			end
			scdg_pkg::SCDG_X4: begin
				step = 6'h04;
				shifted = {acc_q[27:0], i_load_data[3:0]};
			end
			scdg_pkg::SCDG_X8: begin
				step = 6'h08;
				shifted = {acc_q[23:0], i_load_data[7:0]};
			end
			scdg_pkg::SCDG_X16: begin
				step = 6'h10;
				shifted = {acc_q[15:0], i_load_data};
			end
		endcase
	end

	// Load handshake stalls while a packed word waits
	assign o_load_ready = (state_q == scdg_pkg::SCDG_LOAD) && !pend_q;

	// Pack narrow transfers into 32-bit words, empty outside a load
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || state_q != scdg_pkg::SCDG_LOAD) begin
			acc_q <= 32'h0000_0000;
			bits_q <= 6'h00;
			pend_q <= 1'b0;
			word_q <= 32'h0000_0000;
		end else begin
			if (pend_q && in_ready) begin
				pend_q <= 1'b0;
			end
			if (i_load_valid && o_load_ready) begin
				acc_q <= shifted;
				if (bits_q + step == 6'h20) begin
					bits_q <= 6'h00;
					pend_q <= 1'b1;
					word_q <= shifted;
				end else begin
					bits_q <= bits_q + step;
				end
			end
		end
	end

	// Buffer flushed outside a load so a cut session leaves no words
	assign fifo_rst_n = i_reset_n && (state_q == scdg_pkg::SCDG_LOAD);

	// Word buffer between load and decrypt
	scdg_fifo #(
		.W(scdg_pkg::WORD_W),
		.DEPTH(scdg_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_reset_n(fifo_rst_n),
		.i_in_valid(pend_q),
		.o_in_ready(in_ready),
		.i_in_data(word_q),
		.o_out_valid(f_valid),
		.i_out_ready(f_ready),
		.o_out_data(f_data)
	);

	// Drain stalls for one cycle on each tag compare
	assign f_ready = (state_q == scdg_pkg::SCDG_LOAD) && !chk_q;
	assign take = f_valid && f_ready;
	assign blk_words = {i_block_cblocks, 2'b00};
	assign is_tag = cfg_q.counting && (grp_q == 4'h8);
	assign plain = cfg_q.encrypted ? (f_data ^ key_q) : f_data;
	assign min_cblk = i_cfg.counting ? scdg_pkg::CC_MIN_CBLK :
		(i_cfg.gen2 ? scdg_pkg::AUTH_MIN_GEN2 :
		scdg_pkg::AUTH_MIN_GEN1);

	// Session checks at start
	always_comb begin
		start_err = 1'b1;
		if (i_cfg.counting && i_cfg.auth) begin
			start_code = scdg_pkg::SCDG_E_MODE;
		end else if (i_cfg.auth && (i_cfg.compressed ||
			i_cfg.partial || i_cfg.staged)) begin
			start_code = scdg_pkg::SCDG_E_FEAT;
		end else if (i_cfg.auth && !i_fuse.hash_prog) begin
			start_code = scdg_pkg::SCDG_E_FUSE;
		end else if ((i_cfg.counting || i_cfg.auth) &&
			(!i_cfg.key_roll || i_block_cblocks < min_cblk)) begin
			start_code = scdg_pkg::SCDG_E_BLK;
		end else begin
			start_code = scdg_pkg::SCDG_E_NONE;
			start_err = 1'b0;
		end
	end

	// Main sequencer
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			state_q <= scdg_pkg::SCDG_IDLE;
			err_q <= scdg_pkg::SCDG_E_NONE;
			cfg_q <= '0;
		end else begin
			unique case (state_q)
				scdg_pkg::SCDG_IDLE, scdg_pkg::SCDG_DONE,
				scdg_pkg::SCDG_ERR: begin
					if (i_start) begin
						cfg_q <= i_cfg;
						err_q <= start_code;
						state_q <= start_err ? scdg_pkg::SCDG_ERR :
							scdg_pkg::SCDG_LOAD;
					end
				end
				scdg_pkg::SCDG_LOAD: begin
					if (chk_q && !chk_ok_q) begin
						err_q <= scdg_pkg::SCDG_E_CHK;
						state_q <= scdg_pkg::SCDG_ERR;
					end else if (take && !is_tag &&
						wr_cnt_q == 13'h1000) begin
						err_q <= scdg_pkg::SCDG_E_OVF;
						state_q <= scdg_pkg::SCDG_ERR;
					end else if (end_q && !f_valid && !pend_q &&
						!chk_q) begin
						state_q <= cfg_q.auth ? scdg_pkg::SCDG_AUTH :
							scdg_pkg::SCDG_DONE;
					end
				end
				scdg_pkg::SCDG_AUTH: begin
					if (i_auth_fail) begin
						err_q <= scdg_pkg::SCDG_E_AUTH;
						state_q <= scdg_pkg::SCDG_ERR;
					end else if (i_auth_ok) begin
						state_q <= (wr_cnt_q == 13'h0000) ?
							scdg_pkg::SCDG_DONE : scdg_pkg::SCDG_RDWR;
					end
				end
				scdg_pkg::SCDG_RDWR: begin
					state_q <= scdg_pkg::SCDG_RDWW;
				end
				scdg_pkg::SCDG_RDWW: begin
					state_q <= ({1'b0, rdw_q} + 13'h0001 == wr_cnt_q) ?
						scdg_pkg::SCDG_DONE : scdg_pkg::SCDG_RDWR;
				end
				default: begin
					state_q <= scdg_pkg::SCDG_IDLE;
				end
			endcase
		end
	end

	// End of bitstream marker from the source
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || state_q != scdg_pkg::SCDG_LOAD) begin
			end_q <= 1'b0;
		end else if (i_load_end) begin
			end_q <= 1'b1;
		end
	end

	// Periodic tag check over eight words in counting mode
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || state_q != scdg_pkg::SCDG_LOAD) begin
			grp_q <= 4'h0;
			sum_q <= 32'h0000_0000;
			chk_q <= 1'b0;
			chk_ok_q <= 1'b1;
		end else begin
			chk_q <= 1'b0;
			if (take && is_tag) begin
				chk_q <= 1'b1;
				chk_ok_q <= (f_data == sum_q);
				grp_q <= 4'h0;
				sum_q <= 32'h0000_0000;
			end else if (take && cfg_q.counting) begin
				grp_q <= grp_q + 4'h1;
				sum_q <= sum_q ^ plain;
			end
		end
	end

	// Key rolling: next key is last word of each block
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			key_q <= scdg_pkg::KEY_RST;
			blk_q <= 18'h00000;
		end else if (i_start && state_q != scdg_pkg::SCDG_LOAD &&
			state_q != scdg_pkg::SCDG_RDWR &&
			state_q != scdg_pkg::SCDG_RDWW &&
			state_q != scdg_pkg::SCDG_AUTH) begin
			key_q <= i_key0;
			blk_q <= 18'h00000;
		end else if ((state_q == scdg_pkg::SCDG_LOAD && take && !is_tag &&
			!cfg_q.auth) || state_q == scdg_pkg::SCDG_RDWW) begin
			if (blk_q + 18'h00001 == blk_words) begin
				blk_q <= 18'h00000;
				if (cfg_q.key_roll) begin
					key_q <= mem_wd;
				end
			end else begin
				blk_q <= blk_q + 18'h00001;
			end
		end
	end

	// Memory write: store on load, decrypt in place on the pass
	always_comb begin
		mem_we = 1'b0;
		mem_wa = wr_cnt_q[11:0];
		mem_wd = cfg_q.auth ? f_data : plain;
		if (state_q == scdg_pkg::SCDG_RDWW) begin
			mem_we = 1'b1;
			mem_wa = rdw_q;
			mem_wd = cfg_q.encrypted ? (rd_q ^ key_q) : rd_q;
		end else if (state_q == scdg_pkg::SCDG_LOAD && take &&
			!is_tag && wr_cnt_q != 13'h1000) begin
			mem_we = 1'b1;
		end
	end

	// Configuration memory array
	always_ff @(posedge i_clk) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
		rd_q <= mem[rd_a];
	end

	// Shared read port address
	assign rd_a = (state_q == scdg_pkg::SCDG_RDWR) ? rdw_q :
		(i_icap_rd_en ? i_icap_addr : i_ext_rb_addr);

	// Stored word count and pass address
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || state_q == scdg_pkg::SCDG_IDLE ||
			(i_start && (state_q == scdg_pkg::SCDG_DONE ||
			state_q == scdg_pkg::SCDG_ERR))) begin
			wr_cnt_q <= 13'h0000;
			rdw_q <= 12'h000;
		end else begin
			if (state_q == scdg_pkg::SCDG_LOAD && mem_we) begin
				wr_cnt_q <= wr_cnt_q + 13'h0001;
			end
			if (state_q == scdg_pkg::SCDG_RDWW) begin
				rdw_q <= rdw_q + 12'h001;
			end
		end
	end

	// Triple-redundant readback lock, vote of three flops
	assign prot = (prot_q[0] & prot_q[1]) | (prot_q[1] & prot_q[2]) |
		(prot_q[0] & prot_q[2]);
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			prot_q <= scdg_pkg::TMR_RST;
		end else if (state_q == scdg_pkg::SCDG_LOAD &&
			(cfg_q.encrypted || cfg_q.auth)) begin
			prot_q <= 3'h7;
		end else begin
			prot_q <= {3{prot}};
		end
	end

	// Scan lock on protected session, held until reset
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			scan_off_q <= 1'b0;
		end else if (state_q == scdg_pkg::SCDG_LOAD &&
			(cfg_q.encrypted || cfg_q.auth)) begin
			scan_off_q <= 1'b1;
		end
	end

	// Readback answers, one cycle after the request
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_ext_rb_valid <= 1'b0;
			o_icap_rd_valid <= 1'b0;
		end else begin
			o_icap_rd_valid <= i_icap_rd_en &&
				state_q != scdg_pkg::SCDG_RDWR;
			o_ext_rb_valid <= i_ext_rb_req && !i_icap_rd_en &&
				state_q != scdg_pkg::SCDG_RDWR &&
				!prot && !i_soft_rb_dis;
		end
	end

	// Status outputs
	assign o_rd_data = rd_q;
	assign o_scan_enable = i_scan_req && !scan_off_q &&
		!i_fuse.scan_disable_fuse;
	assign o_rb_locked = prot;
	assign o_done = (state_q == scdg_pkg::SCDG_DONE);
	assign o_err = err_q;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	mode_excl_a: assert property (
		state_q == scdg_pkg::SCDG_LOAD |-> !(cfg_q.counting && cfg_q.auth))
		else $error("both countermeasures active");
	feat_rej_a: assert property (
		state_q == scdg_pkg::SCDG_IDLE && i_start && i_cfg.auth &&
		i_cfg.partial && !i_cfg.counting |=>
		state_q == scdg_pkg::SCDG_ERR &&
		o_err == scdg_pkg::SCDG_E_FEAT)
		else $error("auth partial not rejected");
	fuse_need_a: assert property (
		$rose(state_q == scdg_pkg::SCDG_LOAD) && cfg_q.auth
		|-> $past(i_fuse.hash_prog))
		else $error("auth without hash fuse");
	blk_min_a: assert property (
		$rose(state_q == scdg_pkg::SCDG_LOAD) && cfg_q.counting
		|-> $past(i_block_cblocks) >= 16'h0004)
		else $error("counting block too small");
	tag_halt_a: assert property (
		chk_q && !chk_ok_q |=> state_q == scdg_pkg::SCDG_ERR ##1
		state_q == scdg_pkg::SCDG_ERR || $past(i_start))
		else $error("tag failure not halted");
	no_tag_a: assert property (
		cfg_q.auth |-> !chk_q)
		else $error("tag check in auth mode");
	rdw_place_a: assert property (
		state_q == scdg_pkg::SCDG_RDWR |=> mem_we &&
		mem_wa == $past(rdw_q))
		else $error("pass wrote wrong address");
	rb_block_a: assert property (
		prot && i_ext_rb_req |=> !o_ext_rb_valid)
		else $error("external readback leaked");
	icap_rd_a: assert property (
		prot && i_icap_rd_en && o_done |=> o_icap_rd_valid)
		else $error("internal port refused");
	lock_hold_a: assert property (
		o_rb_locked |=> o_rb_locked && scan_off_q)
		else $error("lock released before reset");
	scan_off_a: assert property (
		scan_off_q || i_fuse.scan_disable_fuse |-> !o_scan_enable)
		else $error("scan enabled when locked");

	pass_c: cover property (state_q == scdg_pkg::SCDG_RDWW ##2
		state_q == scdg_pkg::SCDG_DONE);
	chk_c: cover property (chk_q && chk_ok_q);
	full_c: cover property (pend_q && !in_ready);
	roll_c: cover property (take && blk_q + 18'h00001 == blk_words);
endmodule : scdg_loader

//--- scdg_cfg_src.sv
// Behavioural external configuration source for the load port
`timescale 1ns/100ps
module scdg_cfg_src (
	// Clock
	input wire logic i_clk,
	// Bench control
	input wire logic i_go,
	input wire logic i_slow,
	input wire scdg_pkg::scdg_width_t i_width,
	input wire logic [5:0] i_n,
	input wire logic [31:0] i_words [32],
	// Load port
	input wire logic i_ready,
	output logic o_valid,
	output logic [15:0] o_data,
	output logic o_end
);
	int w;

	// Each word goes as 32/w slices, first slice from the MSBs
	initial begin
		o_valid = 1'h0;
		o_data = 16'h0000;
		o_end = 1'h0;
		forever begin
			@(posedge i_clk);
			if (i_go) begin
				@(negedge i_clk);
				w = (i_width == scdg_pkg::SCDG_X1) ? 1 : 2 << i_width;
				for (int k = 0; k < int'(i_n); k++) begin
					for (int b = 32 - w; b >= 0; b -= w) begin
						o_valid = 1'h1;
						o_data = 16'(i_words[k] >> b) & 16'((17'h1 << w) - 17'h1);
						// Hold until ready is seen before the taking edge
						while (!i_ready) @(negedge i_clk);
						@(negedge i_clk);
						// Idle lines show the inverse of the last value
						if (i_slow) begin
							o_valid = 1'h0;
							o_data = ~o_data;
							@(negedge i_clk);
						end
					end
				end
				o_valid = 1'h0;
				o_data = ~o_data;
				o_end = 1'h1;
				@(negedge i_clk);
				o_end = 1'h0;
			end
		end
	end
endmodule : scdg_cfg_src

//--- tb_top.sv
// Self-checking bench for the secure configuration loader
`timescale 1ns/100ps
module tb_top;
	// Start options, fuses, block size, error, ready, lock
	typedef struct {
		logic [7:0] c;
		logic [1:0] f;
		logic [15:0] b;
		logic [2:0] e;
		logic r;
		logic l;
	} scdg_row_t;
	scdg_row_t rows [13] = '{
		'{8'hF0, 2'h2, 16'h0100, 3'h1, 1'h0, 1'h0},
		'{8'h78, 2'h2, 16'h0100, 3'h2, 1'h0, 1'h0},
		'{8'h74, 2'h2, 16'h0100, 3'h2, 1'h0, 1'h0},
		'{8'h72, 2'h2, 16'h0100, 3'h2, 1'h0, 1'h0},
		'{8'h70, 2'h0, 16'h0100, 3'h3, 1'h0, 1'h0},
		'{8'h90, 2'h0, 16'h0004, 3'h4, 1'h0, 1'h0},
		'{8'hB0, 2'h0, 16'h0003, 3'h4, 1'h0, 1'h0},
		'{8'h70, 2'h2, 16'h00F5, 3'h4, 1'h0, 1'h0},
		'{8'h71, 2'h2, 16'h00B9, 3'h4, 1'h0, 1'h0},
		'{8'h70, 2'h2, 16'h00F6, 3'h0, 1'h1, 1'h1},
		'{8'h71, 2'h2, 16'h00BA, 3'h0, 1'h1, 1'h1},
		'{8'hB0, 2'h0, 16'h0004, 3'h0, 1'h1, 1'h1},
		'{8'h00, 2'h0, 16'h0000, 3'h0, 1'h1, 1'h0}
	};
	logic i_clk, i_reset_n, i_start, i_auth_ok, i_auth_fail;
	scdg_pkg::scdg_cfg_t i_cfg;
	scdg_pkg::scdg_fuse_t i_fuse;
	logic [15:0] i_block_cblocks, i_load_data;
	logic [31:0] i_key0, o_rd_data;
	scdg_pkg::scdg_width_t i_load_width;
	logic i_load_valid, i_load_end, o_load_ready, i_scan_req;
	logic i_soft_rb_dis, i_ext_rb_req, i_icap_rd_en;
	logic [11:0] i_ext_rb_addr, i_icap_addr;
	logic o_ext_rb_valid, o_icap_rd_valid, o_scan_enable;
	logic o_rb_locked, o_done;
	scdg_pkg::scdg_err_t o_err;
	logic p_go, p_slow;
	logic [5:0] p_n;
	logic [31:0] p_w [32];
	logic [31:0] pl [32];
	int err_total, n_checks;

	scdg_loader i_scdg_loader (.i_clk, .i_reset_n, .i_start, .i_cfg,
		.i_fuse, .i_block_cblocks, .i_key0, .i_auth_ok, .i_auth_fail,
		.i_load_width, .i_load_valid, .i_load_data, .i_load_end,
		.o_load_ready, .i_soft_rb_dis, .i_ext_rb_req, .i_ext_rb_addr,
		.i_icap_rd_en, .i_icap_addr, .o_ext_rb_valid, .o_icap_rd_valid,
		.o_rd_data, .i_scan_req, .o_scan_enable, .o_rb_locked, .o_done,
		.o_err);
	scdg_cfg_src i_scdg_cfg_src (.i_clk, .i_go(p_go), .i_slow(p_slow),
		.i_width(i_load_width), .i_n(p_n), .i_words(p_w),
		.i_ready(o_load_ready), .o_valid(i_load_valid),
		.o_data(i_load_data), .o_end(i_load_end));

	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim

	task automatic rst();
		i_reset_n = 1'h0;
		repeat (10) @(negedge i_clk);
		i_reset_n = 1'h1;
		@(negedge i_clk);
	endtask : rst

	task automatic go(logic [7:0] c, logic [15:0] b);
		i_cfg = c;
		i_block_cblocks = b;
		i_start = 1'h1;
		@(negedge i_clk);
		i_start = 1'h0;
		repeat (2) @(negedge i_clk);
	endtask : go

	task automatic run(scdg_pkg::scdg_width_t w, logic s);
		i_load_width = w;
		p_slow = s;
		p_go = 1'h1;
		@(negedge i_clk);
		p_go = 1'h0;
	endtask : run

	// Bounded wait for done or an error
	task automatic fin(int n);
		for (int c = 0; c < n && o_done !== 1'h1 && o_err === 3'h0; c++)
			@(negedge i_clk);
	endtask : fin

	// One read, internal port when x is set
	task automatic rb(logic x, logic [11:0] a, logic v, logic [31:0] e);
		i_icap_rd_en = x;
		i_ext_rb_req = !x;
		i_icap_addr = a;
		i_ext_rb_addr = a;
		@(negedge i_clk);
		i_icap_rd_en = 1'h0;
		i_ext_rb_req = 1'h0;
		chk("rb_valid", x ? o_icap_rd_valid : o_ext_rb_valid, v);
		if (v) chk("rd_data", o_rd_data, e);
		// Idle cycle so the next read raises its request afresh
		@(negedge i_clk);
	endtask : rb

	// Plain words, their cipher stream, tags and key rolling
	task automatic build(logic [31:0] k, int np, logic tg,
		logic [31:0] bad, int kb);
		logic [31:0] t;
		int n;
		t = 32'h0;
		n = 0;
		for (int j = 0; j < np; j++) begin
			pl[j] = 32'h1357_9BDF ^ (32'(j) * 32'h0102_0409);
			p_w[n] = pl[j] ^ k;
			n++;
			t ^= pl[j];
			if (tg && j % 8 == 7) begin
				p_w[n] = t ^ bad;
				n++;
				t = 32'h0;
			end
			if (j % kb == kb - 1) k = pl[j];
		end
		p_n = 6'(n);
	endtask : build

	// 100 MHz clock
	initial begin
		i_clk = 1'h0;
		forever #5 i_clk = ~i_clk;
	end

	// Watchdog at several times the expected run of about 1200 cycles
	initial begin
		#100000;
		err_total++;
		end_sim();
	end

	// Main sequence
	initial begin
		{i_start, i_auth_ok, i_auth_fail} = 3'h0;
		i_load_width = scdg_pkg::SCDG_X16;
		{i_soft_rb_dis, i_ext_rb_req, i_icap_rd_en, p_go, p_slow} = 5'h00;
		i_cfg = 8'h00;
		i_fuse = 2'h0;
		i_block_cblocks = 16'h0000;
		i_key0 = 32'hA5C3_0F69;
		i_ext_rb_addr = 12'h000;
		i_icap_addr = 12'h000;
		i_scan_req = 1'h1;
		p_n = 6'h00;
		err_total = 0;
		n_checks = 0;
		foreach (rows[i]) begin
			i_fuse = rows[i].f;
			rst();
			go(rows[i].c, rows[i].b);
			chk("err", o_err, rows[i].e);
			chk("ready", o_load_ready, rows[i].r);
			chk("lock", o_rb_locked, rows[i].l);
			chk("scan", o_scan_enable, !rows[i].l);
		end
		// Counting mode, x16, key rolls every 16 words
		i_fuse = 2'h0;
		rst();
		go(8'hB0, 16'h0004);
		build(i_key0, 24, 1'h1, 32'h0, 16);
		run(scdg_pkg::SCDG_X16, 1'h0);
		fin(600);
		chk("done", o_done, 1'h1);
		chk("scan", o_scan_enable, 1'h0);
		for (int j = 0; j < 24; j++) rb(1'h1, 12'(j), 1'h1, pl[j]);
		rb(1'h0, 12'h000, 1'h0, 32'h0);
		rst();
		chk("lock", o_rb_locked, 1'h0);
		chk("scan", o_scan_enable, 1'h1);
		// Bad tag on the first group, x8, slow source
		go(8'hB0, 16'h0004);
		build(i_key0, 8, 1'h1, 32'h0000_0100, 16);
		run(scdg_pkg::SCDG_X8, 1'h1);
		fin(600);
		chk("err", o_err, 3'h6);
		chk("done", o_done, 1'h0);
		// Auth mode, x4, restarted from the error state: cipher held
		// until authenticated, then pass; storage starts at word 0
		i_fuse = 2'h2;
		go(8'h71, 16'h00BA);
		build(i_key0, 9, 1'h0, 32'h0, 744);
		run(scdg_pkg::SCDG_X4, 1'h0);
		fin(300);
		rb(1'h1, 12'h008, 1'h1, p_w[8]);
		i_auth_ok = 1'h1;
		@(negedge i_clk);
		i_auth_ok = 1'h0;
		fin(300);
		chk("done", o_done, 1'h1);
		chk("err", o_err, 3'h0);
		for (int j = 0; j < 9; j++) rb(1'h1, 12'(j), 1'h1, pl[j]);
		// Auth mode, x1, authentication fails
		rst();
		go(8'h70, 16'h00F6);
		build(i_key0, 2, 1'h0, 32'h0, 744);
		run(scdg_pkg::SCDG_X1, 1'h1);
		fin(300);
		i_auth_fail = 1'h1;
		@(negedge i_clk);
		i_auth_fail = 1'h0;
		fin(20);
		chk("err", o_err, 3'h7);
		// Plain load: external readback follows the soft bit
		i_fuse = 2'h0;
		rst();
		go(8'h00, 16'h0000);
		build(32'h0, 2, 1'h0, 32'h0, 744);
		run(scdg_pkg::SCDG_X16, 1'h0);
		fin(300);
		chk("lock", o_rb_locked, 1'h0);
		rb(1'h0, 12'h001, 1'h1, pl[1]);
		i_soft_rb_dis = 1'h1;
		rb(1'h0, 12'h001, 1'h0, 32'h0);
		rb(1'h1, 12'h001, 1'h1, pl[1]);
		i_soft_rb_dis = 1'h0;
		// Scan fuse keeps scan off
		i_fuse = 2'h1;
		rst();
		chk("scan", o_scan_enable, 1'h0);
		end_sim();
	end
endmodule : tb_top
